// ### spg_channel.sv
// one compare channel: clamps the value and drives the compare output
`timescale 1ns/1ps
module spg_channel
   import spg_pkg::*;
(
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   spg_tick_if.chan              tk,
   input  wire logic [VAL_W-1:0] value_i,
   input  wire logic             invert_i,
   output logic                  cmp_o
);
   logic [CNT_W-1:0] val_used;
   logic             cmp_r;
   logic             cmp_nxt;
   logic             raw;

   // underflow clamps to zero, positive values pass unchanged
   always_comb begin
      val_used = value_i[VAL_W-1] ? '0 : value_i[CNT_W-1:0];        // see [R15] [R13]
   end

   // ----------------------------------------
   // compare, evaluated only on pwm ticks
   // ----------------------------------------
   always_comb begin
      cmp_nxt = cmp_r;
      raw     = cmp_r ^ invert_i;
      if (tk.tick) begin                                             // see [R22]
         if (val_used == '0) begin
            raw = 1'b0;                                              // see [R14]
         end else if (val_used >= tk.modulus) begin
            raw = 1'b1;                                              // see [R14]
         end else if (tk.edge_mode) begin
            // active from period start until match: width = value ticks
            if (tk.count == CNT_ONE) begin
               raw = 1'b1;                                           // see [R17] [R12]
            end
            if (tk.count == val_used + CNT_ONE) begin
               raw = 1'b0;                                           // see [R09]
            end
         end else begin
            if (tk.down && (val_used > tk.count)) begin
               raw = 1'b1;                                           // see [R08] [R16]
            end
            if (!tk.down && (val_used == tk.count)) begin
               raw = 1'b0;                                           // see [R09] [R16]
            end
         end
         cmp_nxt = raw ^ invert_i;                                   // see [R08] [R09] [R13]
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmp_r <= 1'b0;
      end else begin
         cmp_r <= cmp_nxt;
      end
   end

   assign cmp_o = cmp_r;
endmodule

// ### spg_inverter_model.sv
// behavioural model of the three inverter legs behind the pwm outputs
`timescale 1ns/1ps
module spg_inverter_model (
   input  wire logic       clk_sys_i,
   input  wire logic [5:0] pwm_i,
   output logic [2:0]      phase_o,
   output logic            shoot_o
);
   // a leg sits high only while its top switch alone conducts
   always_ff @(posedge clk_sys_i) begin
      for (int p = 0; p < 3; p++) phase_o[p] <= pwm_i[2*p] & ~pwm_i[2*p+1];
      shoot_o <= |(pwm_i & {pwm_i[4], pwm_i[5], pwm_i[2], pwm_i[3], pwm_i[0], pwm_i[1]});
   end
endmodule

// ### spg_pkg.sv
// package of constants and types for the six channel pwm generator
package spg_pkg;
   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int NUM_CH      = 6;
   localparam int NUM_PAIR    = 3;
   localparam int CNT_W       = 15;
   localparam int VAL_W       = 16;
   localparam int REL_W       = 4;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [1:0]       PRSC_RST = 2'h0;
   localparam logic [CNT_W-1:0] CNT_RST  = 15'h0001;
   localparam logic [CNT_W-1:0] CNT_ONE  = 15'h0001;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      SPG_SRC_GEN,
      SPG_SRC_GPIO,
      SPG_SRC_TIMER,
      SPG_SRC_ADC
   } spg_src_t;
endpackage

// ### spg_tick_if.sv
// interface carrying the pwm clock tick, count and direction to the channels
`timescale 1ns/1ps
interface spg_tick_if;
   import spg_pkg::*;
   logic             tick;
   logic [CNT_W-1:0] count;
   logic             down;
   logic             edge_mode;
   logic [CNT_W-1:0] modulus;
   modport gen (output tick, output count, output down, output edge_mode, output modulus);
   modport chan (input tick, input count, input down, input edge_mode, input modulus);
endinterface

// ### spg_top.sv
// six channel pwm generator core: prescaler, shared counter, channels, pair sources
//
// Contract
// [R01] outputs pair freely: complementary or independent
// [R02] one 15-bit counter shared by all channels
// [R03] resolution one tick edge, two center
// [R04] operation clock is system or 3x rate
// [R05] prescaler divides by 1, 2, 4, 8
// [R06] prescaler change waits for load_okay and reload
// [R07] edge_align_select picks up-only or up/down
// [R08] counting down, value above count drives active
// [R09] counting up, value equal count drives inactive
// [R10] modulus zero is illegal, guarantees still hold
// [R11] center period is modulus times two ticks
// [R12] edge period is modulus ticks
// [R13] signed value; inversion gives period minus width
// [R14] value zero/below off, modulus/above fully on
// [R15] values 8000-ffff clamp to zero
// [R16] center pulse width is twice the value
// [R17] edge pulse width equals the value
// [R18] each pair picks generator, gpio, timer, adc
// [R19] all pairs external: no sync, no reload
// [R20] reload every 1 to 16 periods, half cycle
// [R21] center complementary: duty changes each half cycle
// [R22] counter and compare advance on prescaler ticks
`timescale 1ns/1ps
module spg_top
   import spg_pkg::*;
(
   input  wire logic                         clk_sys_i,
   input  wire logic                         rst_n_i,
   input  wire logic                         clk3x_en_i,
   input  wire logic                         op_clk_sel_i,
   input  wire logic [1:0]                   prescale_select_i,
   input  wire logic                         load_okay_i,
   input  wire logic                         edge_align_select_i,
   input  wire logic [CNT_W-1:0]             counter_modulus_i,
   input  wire logic [REL_W-1:0]             reload_rate_i,
   input  wire logic                         half_reload_i,
   input  wire logic [NUM_CH-1:0]            compare_invert_i,
   input  wire logic [NUM_PAIR-1:0]          independent_i,
   input  wire logic [NUM_PAIR-1:0]          asym_i,
   input  wire logic [NUM_CH*VAL_W-1:0]      channel_value_i,
   input  wire logic [NUM_PAIR*2-1:0]        source_sel_i,
   input  wire logic [NUM_PAIR-1:0]          gpio_src_i,
   input  wire logic [NUM_PAIR-1:0]          timer_src_i,
   input  wire logic [NUM_PAIR-1:0]          adc_high_i,
   input  wire logic [NUM_PAIR-1:0]          adc_low_i,
   output logic [NUM_CH-1:0]                 pwm_o,
   output logic                              reload_o,
   output logic                              sync_o,
   output logic                              load_okay_clr_o,
   output logic [CNT_W-1:0]                  count_o,
   output logic                              count_down_o
);
   // ----------------------------------------
   // signals
   // ----------------------------------------
   spg_tick_if tk ();

   logic             op_en;
   logic [1:0]       prsc_r,  prsc_nxt;
   logic [2:0]       div_r,   div_nxt;
   logic             tick;
   logic [CNT_W-1:0] cnt_r,   cnt_nxt;
   logic             down_r,  down_nxt;
   logic [REL_W-1:0] rel_r,   rel_nxt;
   logic             reload_r, reload_nxt;
   logic             sync_r,  sync_nxt;
   logic             ldclr_r, ldclr_nxt;
   logic             all_ext;
   logic             period_end;
   logic             half_point;
   logic [2:0]       div_mask;
   logic [NUM_CH-1:0] cmp;
   logic [NUM_CH-1:0] pwm_r, pwm_nxt;
   logic [NUM_PAIR-1:0] pair_src;

   // ----------------------------------------
   // operation clock and prescaler
   // ----------------------------------------
   // the 3x rate is modelled as an enable train; at 1x every cycle counts
   assign op_en = op_clk_sel_i ? clk3x_en_i : 1'b1;                  // see [R04]

   always_comb begin
      unique case (prsc_r)                                           // see [R05]
         2'h0:    div_mask = 3'h0;
         2'h1:    div_mask = 3'h1;
         2'h2:    div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   end

   assign tick = op_en && ((div_r & div_mask) == 3'h0);              // see [R22]

   always_comb begin
      div_nxt = div_r;
      if (op_en) begin
         div_nxt = 3'((div_r + 3'h1) & div_mask);
      end
   end

   // ----------------------------------------
   // shared counter
   // ----------------------------------------
   assign all_ext    = (source_sel_i[1:0] != 2'h0) && (source_sel_i[3:2] != 2'h0)
                       && (source_sel_i[5:4] != 2'h0);
   // modulus zero: edge counter holds at one, center counter runs up to 7fff; outputs stay bounded
   // center counts 0..mod-1 up and mod-1..0 down, both ends held twice, so a
   // period is 2*mod ticks and a pulse is symmetric around the bottom
   assign period_end = edge_align_select_i ? (cnt_r >= counter_modulus_i)
                                           : (down_r && cnt_r == '0);
   assign half_point = !edge_align_select_i && !down_r
                       && (cnt_r >= 15'(counter_modulus_i - CNT_ONE));

   always_comb begin
      cnt_nxt    = cnt_r;
      down_nxt   = down_r;
      rel_nxt    = rel_r;
      prsc_nxt   = prsc_r;
      reload_nxt = 1'b0;
      sync_nxt   = 1'b0;
      ldclr_nxt  = 1'b0;
      if (tick) begin                                                // see [R22] [R02]
         if (edge_align_select_i) begin                              // see [R07]
            down_nxt = 1'b0;
            cnt_nxt  = period_end ? CNT_ONE : cnt_r + CNT_ONE;       // see [R12] [R03]
         end else if (half_point) begin
            down_nxt = 1'b1;                                         // see [R11] [R03]
            cnt_nxt  = cnt_r;
         end else if (period_end) begin
            down_nxt = 1'b0;                                         // see [R11] [R16]
            cnt_nxt  = cnt_r;
         end else begin
            cnt_nxt  = down_r ? cnt_r - CNT_ONE : cnt_r + CNT_ONE;
         end
         if (period_end || (half_reload_i && half_point)) begin      // see [R20]
            if (rel_r == reload_rate_i) begin
               rel_nxt = '0;
               if (!all_ext) begin                                   // see [R19]
                  reload_nxt = 1'b1;
                  sync_nxt   = 1'b1;
                  if (load_okay_i) begin
                     prsc_nxt  = prescale_select_i;                  // see [R06]
                     ldclr_nxt = 1'b1;
                  end
               end
            end else begin
               rel_nxt = rel_r + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prsc_r   <= PRSC_RST;
         div_r    <= 3'h0;
         cnt_r    <= CNT_RST;
         down_r   <= 1'b0;
         rel_r    <= '0;
         reload_r <= 1'b0;
         sync_r   <= 1'b0;
         ldclr_r  <= 1'b0;
      end else begin
         prsc_r   <= prsc_nxt;
         div_r    <= div_nxt;
         cnt_r    <= cnt_nxt;
         down_r   <= down_nxt;
         rel_r    <= rel_nxt;
         reload_r <= reload_nxt;
         sync_r   <= sync_nxt;
         ldclr_r  <= ldclr_nxt;
      end
   end

   assign tk.tick      = tick;
   assign tk.count     = cnt_r;
   assign tk.down      = down_r;
   assign tk.edge_mode = edge_align_select_i;
   assign tk.modulus   = counter_modulus_i;

   // ----------------------------------------
   // channels
   // ----------------------------------------
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      spg_channel u_ch (
         .clk_sys_i (clk_sys_i),
         .rst_n_i   (rst_n_i),
         .tk        (tk),
         .value_i   (channel_value_i[c*VAL_W +: VAL_W]),
         .invert_i  (compare_invert_i[c]),
         .cmp_o     (cmp[c])
      );
   end

   // ----------------------------------------
   // pair sources and pairing
   // ----------------------------------------
   always_comb begin
      pwm_nxt = pwm_r;
      for (int p = 0; p < NUM_PAIR; p++) begin
         unique case (spg_src_t'(source_sel_i[2*p +: 2]))            // see [R18]
            SPG_SRC_GEN: begin
               // asymmetric: even value rules counting up, odd counting down
               if (asym_i[p] && !edge_align_select_i && !independent_i[p]) begin
                  pair_src[p] = down_r ? cmp[2*p+1] : cmp[2*p];      // see [R21]
               end else begin
                  pair_src[p] = cmp[2*p];
               end
            end
            SPG_SRC_GPIO:  pair_src[p] = gpio_src_i[p];
            SPG_SRC_TIMER: pair_src[p] = timer_src_i[p];
            SPG_SRC_ADC:   pair_src[p] = adc_high_i[p] & ~adc_low_i[p];
         endcase
         if (independent_i[p] && source_sel_i[2*p +: 2] == 2'h0) begin  // see [R01]
            pwm_nxt[2*p]   = cmp[2*p];
            pwm_nxt[2*p+1] = cmp[2*p+1];
         end else begin
            pwm_nxt[2*p]   = pair_src[p];
            pwm_nxt[2*p+1] = ~pair_src[p];
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwm_r <= '0;
      end else begin
         pwm_r <= pwm_nxt;
      end
   end

   assign pwm_o           = pwm_r;
   assign reload_o        = reload_r;
   assign sync_o          = sync_r;
   assign load_okay_clr_o = ldclr_r;
   assign count_o         = cnt_r;
   assign count_down_o    = down_r;
endmodule

// ### spg_top_checker.sv
// assertion checker for the six channel pwm generator core
`timescale 1ns/1ps
module spg_top_checker
   import spg_pkg::*;
(
   input wire logic               clk_sys_i,
   input wire logic               rst_n_i,
   input wire logic               load_okay_i,
   input wire logic               edge_align_select_i,
   input wire logic [CNT_W-1:0]   counter_modulus_i,
   input wire logic [NUM_PAIR-1:0] independent_i,
   input wire logic [5:0]         source_sel_i,
   input wire logic [2:0]         gpio_src_i,
   input wire logic [NUM_CH-1:0]  pwm_o,
   input wire logic               reload_o,
   input wire logic               sync_o,
   input wire logic               load_okay_clr_o,
   input wire logic [CNT_W-1:0]   count_o,
   input wire logic               count_down_o
);
   logic all_ext;
   assign all_ext = (|source_sel_i[1:0]) & (|source_sel_i[3:2]) & (|source_sel_i[5:4]);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // ----
   // assertions
   // ----
   chk_edge_up_only: assert property (edge_align_select_i [*3] |-> !count_down_o)
      else $error("counter runs down in edge mode");
   chk_count_step: assert property ($changed(count_o) |-> count_o == $past(count_o) + CNT_ONE ||
      count_o == $past(count_o) - CNT_ONE || count_o == CNT_ONE) else $error("count jumped");
   chk_edge_wrap: assert property (edge_align_select_i && count_o == counter_modulus_i ##1
      $changed(count_o) && $stable(counter_modulus_i) && edge_align_select_i |-> count_o == CNT_ONE)
      else $error("edge count did not wrap to one");
   chk_center_turn: assert property (!edge_align_select_i && !count_down_o
      && count_o == counter_modulus_i - CNT_ONE ##1 $changed(count_down_o) && $stable(counter_modulus_i)
      && !edge_align_select_i |-> count_down_o && count_o == counter_modulus_i - CNT_ONE)
      else $error("center count did not turn");
   chk_sync_reload: assert property (sync_o |-> reload_o) else $error("sync without reload");
   chk_ext_quiet: assert property (all_ext [*3] |-> !reload_o && !sync_o)
      else $error("reload or sync with all pairs external");
   chk_pair_comp: assert property ((!independent_i[1]) [*3] |-> pwm_o[3] != pwm_o[2])
      else $error("pair outputs not complementary");
   chk_gpio_follow: assert property ((source_sel_i[3:2] == 2'h1 && $stable(gpio_src_i[1])) [*3]
      |-> pwm_o[2] == gpio_src_i[1]) else $error("pair does not follow gpio source");
   chk_load_clear: assert property (load_okay_clr_o |-> $past(load_okay_i))
      else $error("prescaler taken without load okay");
   cov_reload: cover property (reload_o);
   cov_turn: cover property (count_down_o && count_o == counter_modulus_i - CNT_ONE);
   cov_clear: cover property (load_okay_clr_o);
endmodule

// ### test_spg_top.sv
// self-checking testbench for the six channel pwm generator core
`timescale 1ns/1ps
bind spg_top spg_top_checker chk_u (.clk_sys_i, .rst_n_i, .load_okay_i, .edge_align_select_i,
   .counter_modulus_i, .independent_i, .source_sel_i, .gpio_src_i, .pwm_o, .reload_o, .sync_o,
   .load_okay_clr_o, .count_o, .count_down_o);
module test_spg_top;
   import spg_pkg::*;
   logic                         clk_sys_i = 1'b0;
   logic                         rst_n_i = 1'b0;
   logic                         clk3x_en_i = 1'b0;
   logic                         op_clk_sel_i = 1'b0;
   logic [1:0]                   prescale_select_i = 2'h0;
   logic                         load_okay_i = 1'b1;
   logic                         edge_align_select_i = 1'b1;
   logic [CNT_W-1:0]             counter_modulus_i = 15'h000a;
   logic [REL_W-1:0]             reload_rate_i = 4'h0;
   logic                         half_reload_i = 1'b0;
   logic [NUM_CH-1:0]            compare_invert_i = 6'h00;
   logic [NUM_PAIR-1:0]          independent_i = 3'h7;
   logic [NUM_PAIR-1:0]          asym_i = 3'h0;
   logic [NUM_CH-1:0][VAL_W-1:0] channel_value_i = '0;
   logic [5:0]                   source_sel_i = 6'h00;
   logic [NUM_PAIR-1:0]          gpio_src_i = 3'h0;
   logic [NUM_PAIR-1:0]          adc_low_i = 3'h0;
   logic [NUM_CH-1:0]            pwm_o;
   logic                         reload_o;
   logic                         sync_o;
   logic                         shoot;
   int                           miscompares = 0;
   int                           tests_run = 0;
   spg_top dut_u (.clk_sys_i, .rst_n_i, .clk3x_en_i, .op_clk_sel_i, .prescale_select_i, .load_okay_i,
      .edge_align_select_i, .counter_modulus_i, .reload_rate_i, .half_reload_i, .compare_invert_i,
      .independent_i, .asym_i, .channel_value_i, .source_sel_i, .gpio_src_i, .timer_src_i(gpio_src_i),
      .adc_high_i(gpio_src_i), .adc_low_i, .pwm_o, .reload_o, .sync_o, .load_okay_clr_o(),
      .count_o(), .count_down_o());
   spg_inverter_model mdl_u (.clk_sys_i, .pwm_i(pwm_o), .phase_o(), .shoot_o(shoot));
   always #2.5 clk_sys_i = ~clk_sys_i;
   // half-rate enable train stands in for the faster operation clock
   always @(posedge clk_sys_i) #1 clk3x_en_i = ~clk3x_en_i;
   // ----
   // tasks
   // ----
   task automatic tk(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t ns: got %0d expected %0d", $time, got, exp);
      end
   endtask
   // bounded loops: a stuck output shows up as a wrong width, never a hang
   task automatic meas(input int c, output logic [15:0] hi, output logic [15:0] per);
      int n;
      for (n = 0; pwm_o[c] !== 1'b0 && n < 2000; n++) tk(1);
      for (n = 0; pwm_o[c] !== 1'b1 && n < 2000; n++) tk(1);
      for (hi = 0; pwm_o[c] === 1'b1 && hi < 2000; hi++) tk(1);
      for (per = hi; pwm_o[c] === 1'b0 && per < 2000; per++) tk(1);
   endtask
   task automatic win(input int n, input int c, output logic [15:0] hi, output logic [15:0] rl);
      hi = 16'h0000;
      rl = 16'h0000;
      repeat (n) begin
         hi += pwm_o[c];
         rl += reload_o | sync_o;
         tk(1);
      end
   endtask
   task automatic finish_test();
      $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #50us;
      miscompares++;
      finish_test();
   end
   // ----
   // tests
   // ----
   initial begin
      logic [15:0] h, p;
      channel_value_i[0] = 16'h0003;
      tk(2);
      rst_n_i = 1'b1;
      tk(30);
      meas(0, h, p);
      cmp(h, 16'h0003);
      cmp(p, 16'h000a);
      compare_invert_i = 6'h01;
      tk(30);
      meas(0, h, p);
      cmp(h, 16'h0007);
      compare_invert_i = 6'h00;
      edge_align_select_i = 1'b0;
      tk(50);
      meas(0, h, p);
      cmp(h, 16'h0006);
      cmp(p, 16'h0014);
      edge_align_select_i = 1'b1;
      counter_modulus_i = 15'h0006;
      channel_value_i[0] = 16'h0002;
      for (int i = 0; i < 4; i++) begin
         prescale_select_i = i[1:0];
         tk(120);
         meas(0, h, p);
         cmp(h, 16'h0002 << i);
         cmp(p, 16'h0006 << i);
      end
      load_okay_i = 1'b0;
      prescale_select_i = 2'h0;
      tk(120);
      meas(0, h, p);
      cmp(p, 16'h0030);
      load_okay_i = 1'b1;
      tk(120);
      op_clk_sel_i = 1'b1;
      tk(30);
      meas(0, h, p);
      cmp(p, 16'h000c);
      op_clk_sel_i = 1'b0;
      channel_value_i[0] = 16'h0006;
      tk(20);
      win(60, 0, h, p);
      cmp(h, 16'h003c);
      channel_value_i[0] = 16'h8000;
      tk(20);
      win(60, 0, h, p);
      cmp(h, 16'h0000);
      channel_value_i[0] = 16'h0002;
      reload_rate_i = 4'h3;
      tk(50);
      win(240, 0, h, p);
      cmp(p, 16'h000a);
      reload_rate_i = 4'h0;
      independent_i = 3'h5;
      for (int s = 1; s < 4; s++) begin
         source_sel_i = {2'h0, s[1:0], 2'h0};
         gpio_src_i = 3'h7;
         tk(4);
         cmp({14'h0000, pwm_o[3:2]}, 16'h0001);
         gpio_src_i = 3'h0;
         tk(4);
         cmp({14'h0000, pwm_o[3:2]}, 16'h0002);
      end
      gpio_src_i = 3'h7;
      adc_low_i = 3'h7;
      tk(4);
      cmp({14'h0000, pwm_o[3:2]}, 16'h0002);
      adc_low_i = 3'h0;
      source_sel_i = 6'h15;
      tk(10);
      win(100, 0, h, p);
      cmp(p, 16'h0000);
      source_sel_i = 6'h00;
      independent_i = 3'h6;
      tk(20);
      meas(1, h, p);
      cmp(h, 16'h0004);
      cmp({15'h0000, shoot}, 16'h0000);
      finish_test();
   end
endmodule
